// ===== design/cid_core.sv
// Multi-cycle core for a subset of an 8-bit instruction set.
// Assumes an asynchronous-read memory: bus_rdata is valid while bus_req.rd is high.
`timescale 1ns/1ns
`default_nettype none
`include "cid_regs.svh"

// Behaviour
// - Opcode 8E halts the oscillator, clears only the mask flag, one fetch cycle.
// - While halted the oscillator stop output is high and a low external interrupt pin wakes it.
// - The test opcodes 3D, 4D, 5D, 6D, 7D, 9E6D set N and Z from the operand and clear V.
// - Absolute mode takes high then low address byte as a 16-bit address.
// - Index word offset mode adds a 16-bit offset to the index pair.
// - Index byte offset mode adds an unsigned byte to the index pair.
// - Plain indexed mode uses the index pair as the address.
// - Stack byte offset mode, prefixed 9E, adds a byte to the stack pointer.
// - Stack word offset mode, prefixed 9E, adds a word to the stack pointer.
// - Index post-increment mode reads at the index pair then bumps it.
// - Index byte offset post-increment adds a byte, then bumps the index pair.
// - The four memory-to-memory move modes are supported.
// - Relative mode adds a signed offset byte to the next instruction address.
// - Bit test and branch fetches the page address byte, then the offset byte.
module cid_core (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // Memory bus
  output cid_pkg::cid_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  // Low power
  input wire logic ext_irq_n,
  output logic osc_stop,
  output logic irq_pin_en,
  // Observed state
  output cid_pkg::cid_arch_t arch
);
  import cid_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic cid_dec_t cid_decode(input logic pre, input logic [7:0] opc);
    cid_dec_t d;
    logic [3:0] hi;
    logic [3:0] lo;
    d = '{op: no_op, mode: implied_mode, tgt: cid_tgt_mem};
    hi = opc[7:4];
    lo = opc[3:0];
    if (pre) begin
      if (hi == `CID_HI_IX1 || hi == `CID_HI_IX2) begin
        d.mode = (hi == `CID_HI_IX1) ? stack_byte_offset_mode : stack_word_offset_mode;
        if (lo == `CID_LO_SUB) d.op = subtract_op;
        if (lo == `CID_LO_STORE) d.op = store_low_index_op;
      end else if (opc == {`CID_HI_IX1M, `CID_LO_TEST}) begin
        d.op = test_zero_negative_op;
        d.mode = stack_byte_offset_mode;
      end
    end else if (opc == `CID_OPC_HALT) begin
      d.op = halt_osc_op;
    end else if (opc == `CID_OPC_TRAP) begin
      d.op = soft_trap_op;
    end else if (opc == `CID_OPC_S2X) begin
      d.op = stack_to_index_op;
    end else if (opc == `CID_OPC_X2S) begin
      d.op = index_to_stack_op;
    end else if (opc == `CID_OPC_BRA || opc == `CID_OPC_BRN || opc == `CID_OPC_BNE ||
                 opc == `CID_OPC_BEQ) begin
      d.op = branch_op;
      d.mode = rel_mode;
    end else if (hi == `CID_HI_BIT) begin
      d.op = bit_branch_op;
      d.mode = page_rel_mode;
    end else if (hi >= `CID_HI_LIT) begin
      case (hi)
        `CID_HI_LIT: d.mode = literal_mode;
        `CID_HI_DIR: d.mode = page_mode;
        `CID_HI_EXT: d.mode = absolute_mode;
        `CID_HI_IX2: d.mode = index_word_offset_mode;
        `CID_HI_IX1: d.mode = index_byte_offset_mode;
        default: d.mode = index_mode;
      endcase
      if (lo == `CID_LO_SUB) d.op = subtract_op;
      if (lo == `CID_LO_STORE && hi != `CID_HI_LIT) d.op = store_low_index_op;
    end else if (lo == `CID_LO_TEST && hi >= `CID_HI_DIRM && hi <= `CID_HI_IXM) begin
      d.op = test_zero_negative_op;
      case (hi)
        `CID_HI_DIRM: d.mode = page_mode;
        `CID_HI_ACC: d.tgt = cid_tgt_acc;
        `CID_HI_XLO: d.tgt = cid_tgt_xlo;
        `CID_HI_IX1M: d.mode = index_byte_offset_mode;
        default: d.mode = index_mode;
      endcase
    end else if (lo == `CID_LO_MOVE && hi >= `CID_HI_ACC && hi <= `CID_HI_IXM) begin
      d.op = move_op;
      case (hi)
        `CID_HI_ACC: d.mode = page_to_page_mode;
        `CID_HI_XLO: d.mode = page_to_postinc_index_mode;
        `CID_HI_IX1M: d.mode = immediate_to_page_mode;
        default: d.mode = postinc_index_to_page_mode;
      endcase
    end else if (lo == `CID_LO_CMPBR && (hi == `CID_HI_IX1M || hi == `CID_HI_IXM)) begin
      d.op = compare_branch_op;
      d.mode = (hi == `CID_HI_IXM) ? index_postinc_mode : index_byte_offset_postinc_mode;
    end
    return d;
  endfunction : cid_decode

  // Operand bytes that follow the opcode
  function automatic logic [1:0] cid_nbytes(input cid_mode_t m);
    case (m)
      implied_mode, index_mode: cid_nbytes = 2'h0;
      absolute_mode, index_word_offset_mode, stack_word_offset_mode,
      index_byte_offset_postinc_mode, immediate_to_page_mode, page_to_page_mode,
      page_rel_mode: cid_nbytes = 2'h2;
      default: cid_nbytes = 2'h1;
    endcase
  endfunction : cid_nbytes

  // Flags after a load-like result: V cleared, N and Z from data
  function automatic logic [7:0] cid_nzv(input logic [7:0] f, input logic [7:0] v);
    logic [7:0] r;
    r = f;
    r[`CID_F_V] = 1'b0;
    r[`CID_F_N] = v[7];
    r[`CID_F_Z] = (v == 8'h00);
    return r;
  endfunction : cid_nzv

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cid_state_t state_q, state_d;
  cid_dec_t dec_q, dec_d;
  logic pre_q, pre_d;
  logic [7:0] opc_q, opc_d;
  logic [1:0] cnt_q, cnt_d;
  logic [15:0] opr_q, opr_d;
  logic [2:0] push_q, push_d;
  cid_bus_req_t req_d;
  logic [7:0] acc_q, acc_d, flags_q, flags_d;
  logic [15:0] hx_q, hx_d, sp_q, sp_d, ip_q, ip_d;
  logic halt_q, halt_d, irqen_q, irqen_d;
  logic [15:0] ea, dst, target;
  logic [7:0] mval, diff, push_val;
  logic [7:0] bit_val;
  logic take;

  // Addresses from the collected operand bytes
  always_comb begin
    target = ip_q + {{8{opr_q[7]}}, opr_q[7:0]};
    dst = {8'h00, opr_q[7:0]};
    case (dec_q.mode)
      absolute_mode: ea = opr_q;
      index_word_offset_mode: ea = hx_q + opr_q;
      index_byte_offset_mode: ea = hx_q + {8'h00, opr_q[7:0]};
      stack_byte_offset_mode: ea = sp_q + {8'h00, opr_q[7:0]};
      stack_word_offset_mode: ea = sp_q + opr_q;
      index_byte_offset_postinc_mode: ea = hx_q + {8'h00, opr_q[15:8]};
      index_mode, index_postinc_mode, postinc_index_to_page_mode: ea = hx_q;
      page_to_page_mode, page_rel_mode: ea = {8'h00, opr_q[15:8]};
      default: ea = {8'h00, opr_q[7:0]};
    endcase
    if (dec_q.mode == page_to_postinc_index_mode) dst = hx_q;
  end

  // Subtract datapath and small selects
  always_comb begin
    mval = (dec_q.mode == literal_mode) ? opr_q[7:0] : bus_rdata;
    diff = acc_q - mval;
    bit_val = bus_rdata >> opc_q[3:1];
    case (push_q)
      3'h0: push_val = ip_q[7:0];
      3'h1: push_val = ip_q[15:8];
      3'h2: push_val = hx_q[7:0];
      3'h3: push_val = acc_q;
      default: push_val = flags_q;
    endcase
    case (opc_q)
      `CID_OPC_BRA: take = 1'b1;
      `CID_OPC_BNE: take = ~flags_q[`CID_F_Z];
      `CID_OPC_BEQ: take = flags_q[`CID_F_Z];
      default: take = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    dec_d = dec_q;
    pre_d = pre_q;
    opc_d = opc_q;
    cnt_d = cnt_q;
    opr_d = opr_q;
    push_d = push_q;
    req_d = bus_req;
    req_d.rd = 1'b0;
    req_d.wr = 1'b0;
    acc_d = acc_q;
    flags_d = flags_q;
    hx_d = hx_q;
    sp_d = sp_q;
    ip_d = ip_q;
    halt_d = halt_q;
    irqen_d = irqen_q;
    case (state_q)
      s_fetch: begin
        req_d.rd = 1'b1;
        req_d.addr = ip_q;
        ip_d = ip_q + 16'h0001;
        pre_d = 1'b0;
        state_d = s_opcode;
      end
      s_opcode: begin
        if (bus_rdata == `CID_PREFIX_STACK && !pre_q) begin
          pre_d = 1'b1;
          req_d.rd = 1'b1;
          req_d.addr = ip_q;
          ip_d = ip_q + 16'h0001;
        end else begin
          dec_d = cid_decode(pre_q, bus_rdata);
          opc_d = bus_rdata;
          cnt_d = cid_nbytes(dec_d.mode);
          state_d = s_address;
          if (cnt_d != 2'h0) begin
            req_d.rd = 1'b1;
            req_d.addr = ip_q;
            ip_d = ip_q + 16'h0001;
            state_d = s_operand;
          end
        end
      end
      s_operand: begin
        opr_d = {opr_q[7:0], bus_rdata};
        cnt_d = cnt_q - 2'h1;
        state_d = s_address;
        if (cnt_q > 2'h1) begin
          req_d.rd = 1'b1;
          req_d.addr = ip_q;
          ip_d = ip_q + 16'h0001;
          state_d = s_operand;
        end
      end
      s_address: begin
        state_d = s_fetch;
        case (dec_q.op)
          halt_osc_op: begin
            flags_d[`CID_F_I] = 1'b0;
            halt_d = 1'b1;
            irqen_d = 1'b1;
            state_d = s_halt;
          end
          soft_trap_op: begin
            push_d = 3'h0;
            state_d = s_push;
          end
          stack_to_index_op: hx_d = sp_q + 16'h0001;
          index_to_stack_op: sp_d = hx_q - 16'h0001;
          branch_op: if (take) ip_d = target;
          store_low_index_op: begin
            req_d.wr = 1'b1;
            req_d.addr = ea;
            req_d.wdata = hx_q[7:0];
            flags_d = cid_nzv(flags_q, hx_q[7:0]);
          end
          no_op: ;
          default: begin
            if (dec_q.op == test_zero_negative_op && dec_q.tgt != cid_tgt_mem) begin
              flags_d = cid_nzv(flags_q,
                (dec_q.tgt == cid_tgt_acc) ? acc_q : hx_q[7:0]);
            end else if (dec_q.op == subtract_op && dec_q.mode == literal_mode) begin
              state_d = s_exec;
            end else if (dec_q.mode == immediate_to_page_mode) begin
              req_d.wr = 1'b1;
              req_d.addr = dst;
              req_d.wdata = opr_q[15:8];
              flags_d = cid_nzv(flags_q, opr_q[15:8]);
            end else begin
              req_d.rd = 1'b1;
              req_d.addr = ea;
              state_d = s_exec;
            end
          end
        endcase
      end
      s_exec: begin
        state_d = s_fetch;
        case (dec_q.op)
          test_zero_negative_op: flags_d = cid_nzv(flags_q, bus_rdata);
          subtract_op: begin
            acc_d = diff;
            flags_d = cid_nzv(flags_q, diff);
            flags_d[`CID_F_V] = (acc_q[7] & ~mval[7] & ~diff[7]) |
                                (~acc_q[7] & mval[7] & diff[7]);
            flags_d[`CID_F_C] = (~acc_q[7] & mval[7]) | (mval[7] & diff[7]) |
                                (diff[7] & ~acc_q[7]);
          end
          compare_branch_op: begin
            if (acc_q == bus_rdata) ip_d = target;
            hx_d = hx_q + 16'h0001;
          end
          bit_branch_op: begin
            flags_d[`CID_F_C] = bit_val[0];
            if (bit_val[0] != opc_q[0]) ip_d = target;
          end
          move_op: begin
            req_d.wr = 1'b1;
            req_d.addr = dst;
            req_d.wdata = bus_rdata;
            flags_d = cid_nzv(flags_q, bus_rdata);
            if (dec_q.mode == page_to_postinc_index_mode ||
                dec_q.mode == postinc_index_to_page_mode) hx_d = hx_q + 16'h0001;
          end
          default: ;
        endcase
      end
      s_push: begin
        req_d.wr = 1'b1;
        req_d.addr = sp_q;
        req_d.wdata = push_val;
        sp_d = sp_q - 16'h0001;
        push_d = push_q + 3'h1;
        if (push_q == `CID_PUSH_LAST) begin
          flags_d[`CID_F_I] = 1'b1;
          irqen_d = 1'b0;
          state_d = s_vreq;
        end
      end
      s_vreq: begin
        req_d.rd = 1'b1;
        req_d.addr = `CID_VEC_TRAP;
        state_d = s_vhi;
      end
      s_vhi: begin
        ip_d[15:8] = bus_rdata;
        req_d.rd = 1'b1;
        req_d.addr = `CID_VEC_TRAP + 16'h0001;
        state_d = s_vlo;
      end
      s_vlo: begin
        ip_d[7:0] = bus_rdata;
        state_d = s_fetch;
      end
      s_halt: begin
        if (!ext_irq_n) begin
          halt_d = 1'b0;
          state_d = s_fetch;
        end
      end
      default: state_d = s_fetch;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sequencer state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= s_fetch;
      dec_q <= '{op: no_op, mode: implied_mode, tgt: cid_tgt_mem};
      pre_q <= 1'b0;
      opc_q <= 8'h00;
      cnt_q <= 2'h0;
      opr_q <= 16'h0000;
      push_q <= 3'h0;
    end else if (ce) begin
      state_q <= state_d;
      dec_q <= dec_d;
      pre_q <= pre_d;
      opc_q <= opc_d;
      cnt_q <= cnt_d;
      opr_q <= opr_d;
      push_q <= push_d;
    end
  end

  // Memory bus request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) bus_req <= '0;
    else if (ce) bus_req <= req_d;
  end

  // Programmer-visible registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= 8'h00;
      flags_q <= `CID_FLAGS_RESET;
      hx_q <= 16'h0000;
      sp_q <= `CID_SP_RESET;
      ip_q <= `CID_IP_RESET;
    end else if (ce) begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      hx_q <= hx_d;
      sp_q <= sp_d;
      ip_q <= ip_d;
    end
  end

  // Oscillator stop and interrupt pin enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      halt_q <= 1'b0;
      irqen_q <= 1'b0;
    end else if (ce) begin
      halt_q <= halt_d;
      irqen_q <= irqen_d;
    end
  end

  assign osc_stop = halt_q;
  assign irq_pin_en = irqen_q;
  assign arch = '{acc: acc_q, index_pair: hx_q, stack_ptr: sp_q,
                  instruction_pointer: ip_q, flag_register: flags_q};
endmodule : cid_core
`default_nettype wire

// ===== design/cid_pkg.sv
// Types for the instruction decode subset core.
// Assumes cid_regs.svh sits beside it.
package cid_pkg;
  typedef enum logic [4:0] {
    implied_mode, literal_mode, page_mode, absolute_mode, index_mode,
    index_byte_offset_mode, index_word_offset_mode, stack_byte_offset_mode,
    stack_word_offset_mode, index_postinc_mode, index_byte_offset_postinc_mode,
    immediate_to_page_mode, page_to_page_mode, page_to_postinc_index_mode,
    postinc_index_to_page_mode, rel_mode, page_rel_mode
  } cid_mode_t;
  typedef enum logic [3:0] {
    no_op, halt_osc_op, test_zero_negative_op, store_low_index_op, subtract_op,
    soft_trap_op, stack_to_index_op, index_to_stack_op, move_op,
    compare_branch_op, bit_branch_op, branch_op
  } cid_op_t;
  typedef enum logic [1:0] {cid_tgt_acc, cid_tgt_xlo, cid_tgt_mem} cid_tgt_t;
  typedef enum logic [3:0] {
    s_fetch, s_opcode, s_operand, s_address, s_exec, s_push, s_vreq, s_vhi,
    s_vlo, s_halt
  } cid_state_t;
  typedef struct packed {
    cid_op_t op;
    cid_mode_t mode;
    cid_tgt_t tgt;
  } cid_dec_t;
  // Memory bus request; read data returns in the same cycle as rd
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cid_bus_req_t;
  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] index_pair;
    logic [15:0] stack_ptr;
    logic [15:0] instruction_pointer;
    logic [7:0] flag_register;
  } cid_arch_t;
endpackage : cid_pkg

// ===== design/cid_regs.svh
// Opcode, flag and reset constants for the instruction decode subset.
// Assumes inclusion by the core only.
`ifndef CID_REGS_SVH
`define CID_REGS_SVH
`define CID_PREFIX_STACK 8'h9E
`define CID_OPC_HALT 8'h8E
`define CID_OPC_TRAP 8'h83
`define CID_OPC_S2X 8'h95
`define CID_OPC_X2S 8'h94
`define CID_OPC_BRA 8'h20
`define CID_OPC_BRN 8'h21
`define CID_OPC_BNE 8'h26
`define CID_OPC_BEQ 8'h27
`define CID_LO_SUB 4'h0
`define CID_LO_CMPBR 4'h1
`define CID_LO_TEST 4'hD
`define CID_LO_MOVE 4'hE
`define CID_LO_STORE 4'hF
`define CID_HI_BIT 4'h0
`define CID_HI_DIRM 4'h3
`define CID_HI_ACC 4'h4
`define CID_HI_XLO 4'h5
`define CID_HI_IX1M 4'h6
`define CID_HI_IXM 4'h7
`define CID_HI_LIT 4'hA
`define CID_HI_DIR 4'hB
`define CID_HI_EXT 4'hC
`define CID_HI_IX2 4'hD
`define CID_HI_IX1 4'hE
`define CID_HI_IX 4'hF
`define CID_F_V 7
`define CID_F_H 4
`define CID_F_I 3
`define CID_F_N 2
`define CID_F_Z 1
`define CID_F_C 0
`define CID_FLAGS_RESET 8'h68
`define CID_SP_RESET 16'h00FF
`define CID_IP_RESET 16'h0000
`define CID_VEC_TRAP 16'hFFFC
`define CID_PUSH_LAST 3'h4
`endif

// ===== test/cid_core_chk.sv
// Checker for bus order, freezing and low-power behaviour of the core.
// Assumes it sees only the core's ports; attached by the bind below.
`timescale 1ns/1ns
`default_nettype none
module cid_core_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Core inputs
  input wire logic ce,
  input wire logic ext_irq_n,
  // Core outputs
  input wire cid_pkg::cid_bus_req_t bus_req,
  input wire logic osc_stop,
  input wire logic irq_pin_en,
  input wire cid_pkg::cid_arch_t arch
);
  import cid_pkg::*;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Halt entry clears the mask and enables the pin
  halt_mask_a: assert property ($rose(osc_stop) |-> !arch.flag_register[3] && irq_pin_en)
    else $error("halt entered without mask clear or pin enable");
  // Halt stands while the pin is idle
  halt_hold_a: assert property (osc_stop && ext_irq_n && ce |=> osc_stop)
    else $error("halt left without wake");
  // No bus traffic while halted
  halt_quiet_a: assert property (osc_stop |-> !bus_req.rd && !bus_req.wr)
    else $error("bus active while halted");
  // Wake leads to a fetch within three cycles
  wake_fetch_a: assert property (osc_stop && !ext_irq_n && ce |-> ##[1:3] bus_req.rd)
    else $error("no fetch after wake");
  // Read and write never together
  rd_wr_excl_a: assert property (!(bus_req.rd && bus_req.wr))
    else $error("read and write together");
  // Clock enable low freezes bus and state
  ce_freeze_a: assert property (!ce |=> $stable(bus_req) && $stable(arch))
    else $error("state moved with enable low");
  // Pin enable drops only with the mask set
  trap_mask_a: assert property ($fell(irq_pin_en) |-> arch.flag_register[3])
    else $error("pin enable dropped with mask clear");
  // Back-to-back pushes walk down one byte at a time
  push_order_a: assert property (bus_req.wr && $past(bus_req.wr) && $past(ce)
    |-> bus_req.addr == $past(bus_req.addr) - 16'h0001)
    else $error("push address not decremented");
  // Vector low byte follows the high byte
  vector_pair_a: assert property (bus_req.rd && bus_req.addr == 16'hFFFD && $past(ce)
    |-> $past(bus_req.rd) && $past(bus_req.addr) == 16'hFFFC)
    else $error("vector bytes out of order");
  // Fixed flag bits read one
  flag_ones_a: assert property (arch.flag_register[6:5] == 2'b11)
    else $error("fixed flag bits not one");
endmodule : cid_core_chk
bind cid_core cid_core_chk chk_u (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .ce(ce),
  .ext_irq_n(ext_irq_n),
  .bus_req(bus_req),
  .osc_stop(osc_stop),
  .irq_pin_en(irq_pin_en),
  .arch(arch)
);
`default_nettype wire

// ===== test/cid_mem_model.sv
// Memory model on the far side of the decode core's bus.
// Assumes asynchronous read and writes taken at the rising edge.
`timescale 1ns/1ns
`default_nettype none
module cid_mem_model (
  // Clock
  input wire logic sys_clk,
  // Bus from the core
  input wire cid_pkg::cid_bus_req_t bus_req,
  output logic [7:0] bus_rdata
);
  import cid_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  // Start from a cleared memory
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    last_q = 8'h00;
  end
  // Data only while a read is asked; otherwise the inverse of the last byte
  always_comb begin
    bus_rdata = bus_req.rd ? mem[bus_req.addr] : ~last_q;
  end
  // Writes and the last byte read
  always @(posedge sys_clk) begin
    if (bus_req.rd) begin
      last_q <= mem[bus_req.addr];
    end
    if (bus_req.wr) begin
      mem[bus_req.addr] <= bus_req.wdata;
    end
  end
endmodule : cid_mem_model
`default_nettype wire

// ===== test/test_cpu_instruction_decode_subset.sv
// Testbench: runs small programs on the decode core against a memory model.
// Assumes cid_pkg, the core, the model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_cpu_instruction_decode_subset;
  import cid_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn;
  logic ce;
  logic ext_irq_n;
  cid_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic osc_stop;
  logic irq_pin_en;
  cid_arch_t arch;
  int fail_count = 0;
  int checks = 0;
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  cid_core uut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .ext_irq_n(ext_irq_n),
    .osc_stop(osc_stop),
    .irq_pin_en(irq_pin_en),
    .arch(arch)
  );
  cid_mem_model mem_u (
    .sys_clk(sys_clk),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp16
  // Place n bytes, first byte in the top of the used part
  task automatic load(input logic [15:0] a, input int n, input logic [255:0] p);
    for (int i = 0; i < n; i++) begin
      mem_u.mem[a + i[15:0]] = p[8*(n-1-i) +: 8];
    end
  endtask : load
  task automatic do_reset;
    @(posedge sys_clk) resetn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp16(arch.stack_ptr, 16'h00FF, "reset stack");
    cmp8(arch.flag_register, 8'h68, "reset flags");
    cmp8({6'h00, bus_req.rd, bus_req.wr}, 8'h00, "reset bus");
    @(posedge sys_clk) resetn <= 1'b1;
  endtask : do_reset
  // Wait for an opcode fetch at a, bounded
  task automatic run_to(input logic [15:0] a);
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge sys_clk);
      if (bus_req.rd === 1'b1 && bus_req.addr === a) break;
    end
    checks++;
    if (n == 300) begin
      fail_count++;
      $display("wrong value at %0t: fetch %h not reached", $time, a);
      end_of_test();
    end
  endtask : run_to
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_alu;
    load(16'h0000, 29,
      256'hA001_955D_BF80_C00200_7D_E005_D00101_2001_FF_4D_2702_2602_A001_21FE_20FE);
    load(16'h0200, 2, 256'h7F80);
    load(16'h0100, 1, 256'h00);
    load(16'h0105, 1, 256'h01);
    mem_u.mem[16'h0080] = 8'hAA;
    do_reset();
    run_to(16'h0002);
    cmp8(arch.acc, 8'hFF, "sub literal acc");
    cmp8(arch.flag_register, 8'h6D, "sub literal flags");
    run_to(16'h0003);
    cmp16(arch.index_pair, 16'h0100, "stack to index");
    cmp8(arch.flag_register, 8'h6D, "transfer flags");
    run_to(16'h0004);
    cmp8(arch.flag_register, 8'h6B, "test index low");
    run_to(16'h0006);
    cmp8(mem_u.mem[16'h0080], 8'h00, "store low index");
    cmp8(arch.flag_register, 8'h6B, "store flags");
    @(posedge sys_clk) ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ce <= 1'b1;
    run_to(16'h0009);
    cmp8(arch.acc, 8'h80, "sub absolute");
    cmp8(arch.flag_register, 8'h6C, "sub absolute flags");
    run_to(16'h000A);
    cmp8(arch.flag_register, 8'h6A, "test plain index");
    run_to(16'h000C);
    cmp8(arch.acc, 8'h7F, "sub byte offset");
    cmp8(arch.flag_register, 8'hE8, "sub overflow flags");
    run_to(16'h000F);
    cmp8(arch.flag_register, 8'hED, "sub word offset");
    run_to(16'h0012);
    run_to(16'h0013);
    cmp8(arch.flag_register, 8'h6D, "test accumulator");
    run_to(16'h001B);
    cmp8(arch.acc, 8'hFF, "conditional branch path");
  endtask : t_alu
  task automatic t_modes;
    load(16'h0000, 30,
      256'h95_9E6D02_9ED00101_6E5A90_4E9091_5E90_7E92_610001_FF_7101_019301_FF_20FE);
    load(16'h0100, 4, 256'h0080FF00);
    load(16'h0200, 1, 256'h01);
    load(16'h0093, 1, 256'hFE);
    do_reset();
    run_to(16'h0004);
    cmp8(arch.flag_register, 8'h6C, "test stack byte");
    run_to(16'h0008);
    cmp8(arch.acc, 8'hFF, "sub stack word");
    run_to(16'h000B);
    cmp8(mem_u.mem[16'h0090], 8'h5A, "literal to page");
    cmp8(arch.flag_register, 8'h69, "move flags");
    run_to(16'h000E);
    cmp8(mem_u.mem[16'h0091], 8'h5A, "page to page");
    run_to(16'h0010);
    cmp8(mem_u.mem[16'h0100], 8'h5A, "page to index");
    cmp16(arch.index_pair, 16'h0101, "postinc store");
    run_to(16'h0012);
    cmp8(mem_u.mem[16'h0092], 8'h80, "index to page");
    cmp16(arch.index_pair, 16'h0102, "postinc load");
    run_to(16'h0016);
    cmp16(arch.index_pair, 16'h0103, "byte offset postinc");
    run_to(16'h0018);
    cmp16(arch.index_pair, 16'h0104, "postinc compare");
    run_to(16'h001C);
    cmp8(arch.flag_register & 8'h01, 8'h00, "bit into carry");
  endtask : t_modes
  task automatic t_halt_trap;
    int n;
    load(16'h0000, 8, 256'h95_7100_94_A010_8E_83);
    load(16'hFFFC, 2, 256'h0040);
    load(16'h0040, 2, 256'h20FE);
    load(16'h00FC, 4, 256'hAAAAAAAA);
    mem_u.mem[16'h0100] = 8'h00;
    do_reset();
    run_to(16'h0004);
    cmp16(arch.stack_ptr, 16'h0100, "index to stack");
    for (n = 0; n < 20 && osc_stop !== 1'b1; n++) @(negedge sys_clk);
    if (n == 20) begin
      fail_count++;
      $display("wrong value at %0t: halt not entered", $time);
      end_of_test();
    end
    cmp8(arch.flag_register, 8'h65, "halt mask clear");
    cmp8({7'h00, irq_pin_en}, 8'h01, "pin enabled");
    repeat (5) @(negedge sys_clk);
    cmp8({7'h00, osc_stop}, 8'h01, "oscillator stopped");
    @(posedge sys_clk) ext_irq_n <= 1'b0;
    run_to(16'h0007);
    @(posedge sys_clk) ext_irq_n <= 1'b1;
    run_to(16'h0040);
    cmp8(mem_u.mem[16'h0100], 8'h08, "push ip low");
    cmp8(mem_u.mem[16'h00FF], 8'h00, "push ip high");
    cmp8(mem_u.mem[16'h00FE], 8'h01, "push index low");
    cmp8(mem_u.mem[16'h00FD], 8'hF0, "push acc");
    cmp8(mem_u.mem[16'h00FC], 8'h65, "push flags");
    cmp16(arch.stack_ptr, 16'h00FB, "stack after trap");
    cmp8(arch.flag_register, 8'h6D, "mask set");
    cmp8({7'h00, irq_pin_en}, 8'h00, "pin enable off");
  endtask : t_halt_trap
  // Main sequence
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    ext_irq_n = 1'b1;
    // Let the model clear its memory before programs are placed
    #1;
    t_alu();
    t_modes();
    t_halt_trap();
    end_of_test();
  end
endmodule : test_cpu_instruction_decode_subset
`default_nettype wire
